// ---- accessory_params.svh ----
`ifndef ACCESSORY_PARAMS_SVH
`define ACCESSORY_PARAMS_SVH

// register addresses on the ulpi immediate register space
`define ADDR_CTRL_WRITE      6'h19
`define ADDR_CTRL_SET        6'h1a
`define ADDR_CTRL_CLEAR      6'h1b
`define ADDR_IE_WRITE        6'h1d
`define ADDR_IE_SET          6'h1e
`define ADDR_IE_CLEAR        6'h1f
`define ADDR_STATUS          6'h20
`define ADDR_LATCH           6'h21

// accessory_switch_control fields
`define CTRL_ID_GND_BIT      1
`define CTRL_TX_ROUTE_BIT    2
`define CTRL_RX_ROUTE_BIT    3
`define CTRL_LEFT_AUDIO_BIT  4
`define CTRL_RIGHT_AUDIO_BIT 5
`define CTRL_MIC_BIT         6
`define CTRL_DATA2_TRI_BIT   7
`define CTRL_WRITE_MASK      8'hfe
`define CTRL_RESET           8'h00

// accessory_interrupt_enable fields
`define IE_OPEN_RISE_BIT     0
`define IE_OPEN_FALL_BIT     1
`define IE_CHARGER_BIT       2
`define IE_RID_DONE_BIT      5
`define IE_WRITE_MASK        8'h27
`define IE_RESET             8'h00

// accessory_interrupt_status / latch fields
`define ST_OPEN_BIT          0
`define ST_CHARGER_BIT       1
`define ST_CODE_LSB          3
`define ST_DONE_BIT          6
`define LATCH_OPEN_BIT       0
`define LATCH_CHARGER_BIT    1
`define LATCH_RID_BIT        3
`define STATUS_RESET         8'h00
`define LATCH_RESET          4'h0
`define RID_CODE_RESET       3'h0

// timing
`define CLK_PERIOD_NS        25
`define RID_CONV_TIME_NS     282000

`endif

// ---- accessory_pkg.sv ----
package accessory_pkg;

    typedef enum logic [1:0]
    {
        op_none,
        op_write,
        op_set,
        op_clear
    } reg_op_t;

    typedef enum logic
    {
        rid_idle,
        rid_busy
    } rid_state_t;

endpackage

// ---- sync_2ff.sv ----
`timescale 1ns/10ps
`default_nettype none

module sync_2ff
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // meta_q feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ---- bsc_reg.sv ----
`timescale 1ns/10ps
`default_nettype none

module bsc_reg
#(
    parameter logic [7:0] WRITE_MASK  = 8'hff,
    parameter logic [7:0] RESET_VALUE = 8'h00
)
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire accessory_pkg::reg_op_t op,
    input  wire logic [7:0]           wdata,
    output logic      [7:0]           q_o
);
    import accessory_pkg::*;

    logic [7:0] d;

    // bits outside the mask never leave their reset value
    always_comb
    begin
        unique case (op)
            op_none:  d = q_o;
            op_write: d = (q_o & ~WRITE_MASK) | (wdata & WRITE_MASK);
            op_set:   d = q_o | (wdata & WRITE_MASK);
            op_clear: d = q_o & ~(wdata & WRITE_MASK);
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            q_o <= RESET_VALUE;
        else
            q_o <= d;
    end

endmodule

`default_nettype wire

// ---- carkit_switch_control_regs.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "accessory_params.svh"

// Operation
// - control register: write, set, clear, same read
// - enable register: write, set, clear, same read
// - data line 1 high while rx route off
// - id_ground_drive pulls ID to ground
// - tx route copies data line 0 to DM
// - rx route copies DP to data line 1
// - left audio enable closes DM switch
// - right or mic enable connects DP
// - data line 2 tri-state or driven zero
// - UART data also reaches closed audio switches
// - any audio enable disables single-ended receivers
// - ID float rise/fall enables raise alt_int
// - charger comparator change raises alt_int when enabled
// - DP-detect fields read zero, do nothing
// - conversion done raises alt_int, enables ORed
// - id_open_status shows ID floating with weak pull on
// - charger_compare_out mirrors comparator with sink on
// - id_resistor_code holds measured resistance code
// - done set after 282 us conversion
// - done cleared only by vendor code read
// - latch records enabled events, clears on read
module carkit_switch_control_regs
#(
    parameter int unsigned RID_CONV_CYCLES =
        (`RID_CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       accessory_mode_sel,
    input  wire logic       id_weak_pull_en,
    input  wire logic       sink_current_en,
    input  wire logic       vendor_rid_ie,
    input  wire logic       vendor_rid_read,
    input  wire logic       rid_start,
    input  wire logic       id_float_pin,
    input  wire logic       charger_comp_pin,
    input  wire logic [2:0] rid_result_pin,
    input  wire logic       data0_pin,
    input  wire logic       dp_pin,
    output logic            alt_int,
    output logic            id_ground_en,
    output logic            dm_out,
    output logic            dm_oe,
    output logic            data1_out,
    output logic            data1_oe,
    output logic            data2_out,
    output logic            data2_oe,
    output logic            left_audio_close,
    output logic            right_audio_close,
    output logic            se_rx_disable,
    output logic      [2:0] id_resistor_code,
    output logic            id_resistor_done
);
    import accessory_pkg::*;

    localparam logic [15:0] RID_LAST = 16'(RID_CONV_CYCLES - 1);

    function automatic reg_op_t decode_op(input logic [5:0] addr,
                                          input logic [5:0] base,
                                          input logic       wr);
        reg_op_t op;
        op = op_none;
        if (wr && addr == base)
            op = op_write;
        else if (wr && addr == base + 6'h01)
            op = op_set;
        else if (wr && addr == base + 6'h02)
            op = op_clear;
        return op;
    endfunction

    // pin inputs
    logic       id_float_s;
    logic       charger_s;
    logic [2:0] rid_result_s;
    logic       data0_s;
    logic       dp_s;

    sync_2ff #(.WIDTH(1)) u_sync_id
    (
        .clk     (clk),
        .reset   (reset),
        .async_i (id_float_pin),
        .sync_o  (id_float_s)
    );

    sync_2ff #(.WIDTH(1)) u_sync_chg
    (
        .clk     (clk),
        .reset   (reset),
        .async_i (charger_comp_pin),
        .sync_o  (charger_s)
    );

    // the code is static once a conversion settles, so a plain bus sync is enough
    sync_2ff #(.WIDTH(3)) u_sync_rid
    (
        .clk     (clk),
        .reset   (reset),
        .async_i (rid_result_pin),
        .sync_o  (rid_result_s)
    );

    sync_2ff #(.WIDTH(1)) u_sync_d0
    (
        .clk     (clk),
        .reset   (reset),
        .async_i (data0_pin),
        .sync_o  (data0_s)
    );

    sync_2ff #(.WIDTH(1)) u_sync_dp
    (
        .clk     (clk),
        .reset   (reset),
        .async_i (dp_pin),
        .sync_o  (dp_s)
    );

    // register bank
    wire reg_op_t ctrl_op = decode_op(reg_addr, `ADDR_CTRL_WRITE, reg_wr);
    wire reg_op_t ie_op   = decode_op(reg_addr, `ADDR_IE_WRITE, reg_wr);

    logic [7:0] ctrl_q;
    logic [7:0] ie_q;

    bsc_reg #(.WRITE_MASK(`CTRL_WRITE_MASK), .RESET_VALUE(`CTRL_RESET)) u_ctrl
    (
        .clk   (clk),
        .reset (reset),
        .op    (ctrl_op),
        .wdata (reg_wdata),
        .q_o   (ctrl_q)
    );

    // mask drops the dp-detect enables and both reserved bits
    bsc_reg #(.WRITE_MASK(`IE_WRITE_MASK), .RESET_VALUE(`IE_RESET)) u_ie
    (
        .clk   (clk),
        .reset (reset),
        .op    (ie_op),
        .wdata (reg_wdata),
        .q_o   (ie_q)
    );

    wire id_gnd_bit   = ctrl_q[`CTRL_ID_GND_BIT];
    wire tx_route_bit = ctrl_q[`CTRL_TX_ROUTE_BIT];
    wire rx_route_bit = ctrl_q[`CTRL_RX_ROUTE_BIT];
    wire left_bit     = ctrl_q[`CTRL_LEFT_AUDIO_BIT];
    wire right_bit    = ctrl_q[`CTRL_RIGHT_AUDIO_BIT];
    wire mic_bit      = ctrl_q[`CTRL_MIC_BIT];
    wire data2_tri    = ctrl_q[`CTRL_DATA2_TRI_BIT];

    // qualified status values
    wire open_now    = id_float_s & id_weak_pull_en;
    wire charger_now = charger_s & sink_current_en;

    logic open_prev_q;
    logic charger_prev_q;
    logic done_prev_q;

    // id resistor conversion timer
    rid_state_t rid_state_q;
    rid_state_t rid_state_d;
    logic [15:0] rid_cnt_q;
    logic [15:0] rid_cnt_d;
    logic [2:0]  code_d;
    logic        done_d;

    wire rid_finish = (rid_state_q == rid_busy) && (rid_cnt_q == RID_LAST);

    always_comb
    begin
        rid_state_d = rid_state_q;
        rid_cnt_d   = rid_cnt_q;
        unique case (rid_state_q)
            rid_idle:
            begin
                if (rid_start)
                begin
                    rid_state_d = rid_busy;
                    rid_cnt_d   = 16'h0000;
                end
            end
            rid_busy:
            begin
                if (rid_finish)
                    rid_state_d = rid_idle;
                else
                    rid_cnt_d = rid_cnt_q + 16'h0001;
            end
        endcase
    end

    assign code_d = rid_finish ? rid_result_s : id_resistor_code;
    // a finishing conversion wins over a vendor read in the same cycle
    assign done_d = rid_finish | (id_resistor_done & ~vendor_rid_read);

    // interrupt events
    wire open_rise   = open_now & ~open_prev_q;
    wire open_fall   = ~open_now & open_prev_q;
    wire ev_open     = (open_rise & ie_q[`IE_OPEN_RISE_BIT]) |
                       (open_fall & ie_q[`IE_OPEN_FALL_BIT]);
    wire ev_charger  = (charger_now ^ charger_prev_q) &
                       ie_q[`IE_CHARGER_BIT];
    wire rid_ie_any  = ie_q[`IE_RID_DONE_BIT] | vendor_rid_ie;
    wire ev_rid      = id_resistor_done & ~done_prev_q & rid_ie_any;

    logic [3:0] latch_q;
    logic [3:0] latch_set;
    logic [3:0] latch_d;

    wire latch_rd = reg_rd && (reg_addr == `ADDR_LATCH);

    always_comb
    begin
        latch_set = 4'h0;
        latch_set[`LATCH_OPEN_BIT]    = ev_open;
        latch_set[`LATCH_CHARGER_BIT] = ev_charger;
        latch_set[`LATCH_RID_BIT]     = ev_rid;
    end

    // an event in the reading cycle stays latched for the next read
    assign latch_d = (latch_q & ~{4{latch_rd}}) | latch_set;

    // read data
    logic [7:0] status_val;

    always_comb
    begin
        status_val = `STATUS_RESET;
        status_val[`ST_OPEN_BIT]    = open_now;
        status_val[`ST_CHARGER_BIT] = charger_now;
        status_val[`ST_CODE_LSB +: 3] = id_resistor_code;
        status_val[`ST_DONE_BIT]    = id_resistor_done;
    end

    wire ctrl_hit = (reg_addr == `ADDR_CTRL_WRITE) || (reg_addr == `ADDR_CTRL_SET) ||
                    (reg_addr == `ADDR_CTRL_CLEAR);
    wire ie_hit   = (reg_addr == `ADDR_IE_WRITE) || (reg_addr == `ADDR_IE_SET) ||
                    (reg_addr == `ADDR_IE_CLEAR);

    // bit 2 of the status and latch stays zero: dp detect is absent
    wire [7:0] rdata_d = ctrl_hit                     ? ctrl_q :
                         ie_hit                       ? ie_q :
                         (reg_addr == `ADDR_STATUS)   ? status_val :
                         (reg_addr == `ADDR_LATCH)    ? {4'h0, latch_q} :
                         8'h00;

    // pin side values, only meaningful while accessory mode owns the data lines
    wire dm_oe_d    = accessory_mode_sel & tx_route_bit;
    wire data1_d    = rx_route_bit ? dp_s : 1'b1;
    wire data1_oe_d = accessory_mode_sel;
    wire data2_oe_d = accessory_mode_sel & ~data2_tri;
    wire audio_any  = left_bit | right_bit | mic_bit;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rid_state_q      <= rid_idle;
            rid_cnt_q        <= 16'h0000;
            id_resistor_code <= `RID_CODE_RESET;
            id_resistor_done <= 1'b0;
            open_prev_q      <= 1'b0;
            charger_prev_q   <= 1'b0;
            done_prev_q      <= 1'b0;
            latch_q          <= `LATCH_RESET;
            alt_int          <= 1'b0;
            reg_rdata        <= 8'h00;
        end
        else
        begin
            rid_state_q      <= rid_state_d;
            rid_cnt_q        <= rid_cnt_d;
            id_resistor_code <= code_d;
            id_resistor_done <= done_d;
            open_prev_q      <= open_now;
            charger_prev_q   <= charger_now;
            done_prev_q      <= id_resistor_done;
            latch_q          <= latch_d;
            alt_int          <= |latch_d;
            if (reg_rd)
                reg_rdata <= rdata_d;
        end
    end

    // switch and pin drivers, one flop stage behind the control register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            id_ground_en      <= 1'b0;
            dm_out            <= 1'b0;
            dm_oe             <= 1'b0;
            data1_out         <= 1'b1;
            data1_oe          <= 1'b0;
            data2_out         <= 1'b0;
            data2_oe          <= 1'b0;
            left_audio_close  <= 1'b0;
            right_audio_close <= 1'b0;
            se_rx_disable     <= 1'b0;
        end
        else
        begin
            id_ground_en      <= id_gnd_bit;
            dm_out            <= data0_s;
            dm_oe             <= dm_oe_d;
            data1_out         <= data1_d;
            data1_oe          <= data1_oe_d;
            data2_out         <= 1'b0;
            data2_oe          <= data2_oe_d;
            // uart levels on DM and DP pass the closed switches unchanged
            left_audio_close  <= left_bit;
            right_audio_close <= right_bit | mic_bit;
            se_rx_disable     <= audio_any;
        end
    end

endmodule

`default_nettype wire

// ---- ctrl_regs_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

module ctrl_regs_sva
#(
    parameter int unsigned RID_CONV_CYCLES = 20
)
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [5:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       accessory_mode_sel,
    input wire logic       vendor_rid_read,
    input wire logic       rid_start,
    input wire logic       alt_int,
    input wire logic       id_ground_en,
    input wire logic       dm_oe,
    input wire logic       data2_oe,
    input wire logic       left_audio_close,
    input wire logic       right_audio_close,
    input wire logic       se_rx_disable,
    input wire logic       id_resistor_done
);
    logic        busy_q;
    int unsigned cnt_q;
    wire         finish = busy_q && cnt_q == RID_CONV_CYCLES;

    // mirror of the converter so the done edge is pinned to the exact cycle
    always_ff @(posedge clk)
    begin
        if (reset || finish)
            busy_q <= 1'b0;
        else if (rid_start)
            busy_q <= 1'b1;
        cnt_q <= (rid_start && !busy_q) ? 1 : cnt_q + 1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence ctrl_write(a, b);
        reg_wr && reg_addr == a && reg_wdata[b];
    endsequence

    se_rx_follow_a:
        assert property (se_rx_disable == (left_audio_close || right_audio_close))
        else $error("receiver disable does not match audio switches");
    id_ground_a:
        assert property (reg_wr && reg_addr == 6'h19 |-> ##2 id_ground_en == $past(reg_wdata[1], 2))
        else $error("id ground drive does not follow written bit");
    right_audio_a:
        assert property (reg_wr && reg_addr == 6'h19 |->
            ##2 right_audio_close == $past(reg_wdata[5] || reg_wdata[6], 2))
        else $error("right switch does not follow bits 5 and 6");
    left_set_a:
        assert property (ctrl_write(6'h1a, 4) |-> ##2 left_audio_close)
        else $error("set address did not close left switch");
    left_clear_a:
        assert property (ctrl_write(6'h1b, 4) |-> ##2 !left_audio_close)
        else $error("clear address did not open left switch");
    mode_gate_a:
        assert property (dm_oe || data2_oe |-> $past(accessory_mode_sel))
        else $error("data line driven outside accessory mode");
    unmapped_read_a:
        assert property (reg_rd && reg_addr == 6'h1c |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rid_done_time_a:
        assert property (finish |=> id_resistor_done)
        else $error("conversion done late");
    rid_done_early_a:
        assert property ($rose(id_resistor_done) |-> $past(finish))
        else $error("conversion done at wrong time");
    done_hold_a:
        assert property (id_resistor_done && !vendor_rid_read |=> id_resistor_done)
        else $error("done flag cleared without vendor read");
    done_clear_a:
        assert property (id_resistor_done && vendor_rid_read && !finish |=> !id_resistor_done)
        else $error("vendor read did not clear done flag");
    alt_clear_a:
        assert property ($fell(alt_int) |-> $past(reg_rd && reg_addr == 6'h21))
        else $error("alt int dropped without latch read");
endmodule

bind carkit_switch_control_regs ctrl_regs_sva #(.RID_CONV_CYCLES(RID_CONV_CYCLES)) u_sva (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .accessory_mode_sel(accessory_mode_sel),
    .vendor_rid_read(vendor_rid_read), .rid_start(rid_start), .alt_int(alt_int),
    .id_ground_en(id_ground_en), .dm_oe(dm_oe), .data2_oe(data2_oe),
    .left_audio_close(left_audio_close), .right_audio_close(right_audio_close),
    .se_rx_disable(se_rx_disable), .id_resistor_done(id_resistor_done)
);

`default_nettype wire

// ---- link_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module link_model
(
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h3f;
        reg_wdata = 8'h00;
    end

    // one-cycle strobe; idle address and data are inverted so stale values never help
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
        q = reg_rdata;
    endtask
endmodule

`default_nettype wire

// ---- test_carkit_switch_control_regs.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_carkit_switch_control_regs;
    localparam int unsigned N = 20;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       mode = 1'b0, pull_en = 1'b0, sink_en = 1'b0, vendor_ie = 1'b0;
    logic       vendor_read = 1'b0, rid_start = 1'b0, id_float = 1'b0, charger = 1'b0;
    logic       data0 = 1'b0, dp = 1'b0;
    logic [2:0] rid_code = 3'h0;
    logic       reg_wr, reg_rd, alt_int, id_ground_en, dm_out, dm_oe, data1_out, data1_oe;
    logic       data2_out, data2_oe, left, right, se_rx, done;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] code_out;
    int         err_total = 0;
    int         samples_checked = 0;
    logic [5:0] addrs [9] = '{6'h19, 6'h1a, 6'h1b, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h1c};
    logic [7:0] routes [8] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h70};
    wire  [7:0] pin_vec = {2'b00, id_ground_en, left, right, se_rx, dm_oe, data2_oe};

    always #12.5 clk = ~clk;

    link_model u_link (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
                       .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    carkit_switch_control_regs #(.RID_CONV_CYCLES(N)) u_dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .accessory_mode_sel(mode),
        .id_weak_pull_en(pull_en), .sink_current_en(sink_en), .vendor_rid_ie(vendor_ie),
        .vendor_rid_read(vendor_read), .rid_start(rid_start), .id_float_pin(id_float),
        .charger_comp_pin(charger), .rid_result_pin(rid_code), .data0_pin(data0), .dp_pin(dp),
        .alt_int(alt_int), .id_ground_en(id_ground_en), .dm_out(dm_out), .dm_oe(dm_oe),
        .data1_out(data1_out), .data1_oe(data1_oe), .data2_out(data2_out),
        .data2_oe(data2_oe), .left_audio_close(left), .right_audio_close(right),
        .se_rx_disable(se_rx), .id_resistor_code(code_out), .id_resistor_done(done));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_link.access(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_link.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic run_rid(input logic [2:0] code);
        @(posedge clk);
        rid_code <= code;
        rid_start <= 1'b1;
        @(posedge clk);
        rid_start <= 1'b0;
        settle(N - 1);
        chk({7'h00, done}, 8'h00);
        settle(1);
        chk({7'h00, done}, 8'h01);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        foreach (addrs[i])
            rd_chk(addrs[i], 8'h00);
        wr(6'h19, 8'hff);
        rd_chk(6'h1b, 8'hfe);
        wr(6'h1b, 8'h1c);
        rd_chk(6'h1a, 8'he2);
        wr(6'h1a, 8'h14);
        rd_chk(6'h19, 8'hf6);
        wr(6'h1d, 8'hff);
        rd_chk(6'h1f, 8'h27);
        wr(6'h1f, 8'h06);
        wr(6'h1e, 8'h08);
        rd_chk(6'h1e, 8'h21);
        wr(6'h20, 8'hff);
        rd_chk(6'h20, 8'h00);
        rd_chk(6'h1c, 8'h00);
        wr(6'h1d, 8'h00);
        $display("test access finished");
        // routes go in before the mode bit, and uart routes never share a value with audio
        foreach (routes[i])
        begin
            wr(6'h19, routes[i]);
            @(posedge clk);
            mode <= 1'b1;
            settle(3);
            chk(pin_vec, {2'b00, routes[i][1], routes[i][4], |routes[i][6:5],
                          |routes[i][6:4], routes[i][2], ~routes[i][7]});
            @(posedge clk);
            mode <= 1'b0;
        end
        wr(6'h19, 8'h00);
        @(posedge clk);
        mode <= 1'b1;
        settle(4);
        chk({5'h00, data2_out, data1_oe, data1_out}, 8'h03);
        wr(6'h1a, 8'h0c);
        settle(5);
        chk({7'h00, data1_out}, 8'h00);
        @(posedge clk);
        dp <= 1'b1;
        data0 <= 1'b1;
        settle(5);
        chk({6'h00, data1_out, dm_out}, 8'h03);
        @(posedge clk);
        dp <= 1'b0;
        data0 <= 1'b0;
        wr(6'h1b, 8'h08);
        settle(5);
        chk({6'h00, data1_out, dm_out}, 8'h02);
        $display("test routing finished");
        @(posedge clk);
        pull_en <= 1'b1;
        sink_en <= 1'b1;
        wr(6'h1d, 8'h07);
        @(posedge clk);
        id_float <= 1'b1;
        settle(6);
        chk({7'h00, alt_int}, 8'h01);
        rd_chk(6'h20, 8'h01);
        rd_chk(6'h21, 8'h01);
        @(posedge clk);
        charger <= 1'b1;
        id_float <= 1'b0;
        settle(6);
        rd_chk(6'h20, 8'h02);
        rd_chk(6'h21, 8'h03);
        chk({7'h00, alt_int}, 8'h00);
        wr(6'h1f, 8'h07);
        @(posedge clk);
        charger <= 1'b0;
        settle(6);
        chk({7'h00, alt_int}, 8'h00);
        @(posedge clk);
        sink_en <= 1'b0;
        charger <= 1'b1;
        settle(6);
        rd_chk(6'h20, 8'h00);
        $display("test events finished");
        wr(6'h1e, 8'h20);
        run_rid(3'b101);
        rd_chk(6'h20, 8'h68);
        rd_chk(6'h20, 8'h68);
        rd_chk(6'h21, 8'h08);
        chk({5'h00, code_out}, 8'h05);
        @(posedge clk);
        vendor_read <= 1'b1;
        @(posedge clk);
        vendor_read <= 1'b0;
        rd_chk(6'h20, 8'h28);
        wr(6'h1f, 8'h20);
        @(posedge clk);
        vendor_ie <= 1'b1;
        run_rid(3'b111);
        settle(2);
        rd_chk(6'h21, 8'h08);
        rd_chk(6'h20, 8'h78);
        $display("test conversion finished");
        conclude();
    end
endmodule

`default_nettype wire
